/* rtl/conv_ctl.sv */
// Function
// - writing a new channel aborts conversion, clears done, restarts on new channel
// - converter-on bit 5 enables and starts; clearing it disables and halts
// - wait low-power state has no effect on conversion
// - halt disables converter; after wake, wait stabilization time before valid results (waits only if converter-on is set at wake; a later enable skips it)
// - done flag bit 7 is read-only and set when a conversion finishes
// - reading result-high or writing control/status clears done flag
// - speed bit 6 read/write; 0 divides cpu clock by 4, 1 by 2
// - bit 4 reserved; software keeps it zero, reads back zero
// - channel-select bits 3:0 read/write, binary code selects input 0 to 15
// - result-high shows result bits 9:2 in positions 7:0
// - result-low shows result bits 1:0, positions 7:2 read zero
// - after reset all three registers read zero
// - enabled converter converts selected channel continuously until disabled
// - each completion overwrites both result bytes; read low then high
`timescale 1ns/100ps
`default_nettype none
`include "conv_ctl_defs.svh"

module conv_ctl (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        wait_mode_i,
   input  wire logic        halt_mode_i,
   input  wire logic [9:0]  core_result_i,
   output logic             converter_on_o,
   output logic [3:0]       channel_select_o,
   output logic             sample_start_o,
   output logic             irq_o
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [1:0] halt_sync_q;
   logic [1:0] wait_sync_q;
   logic       halt_s;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         halt_sync_q <= 2'h0;
         wait_sync_q <= 2'h0;
      end else begin
         halt_sync_q <= {halt_sync_q[0], halt_mode_i};
         wait_sync_q <= {wait_sync_q[0], wait_mode_i};
      end
   end
   assign halt_s = halt_sync_q[1];
   // wait level is synchronised but deliberately steers nothing

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   logic access_s;
   logic wr_s;
   logic rd_s;
   logic mapped_s;
   logic wr_ccs_s;
   logic rd_rhb_s;

   assign access_s = psel_i & penable_i & pready_o;
   assign wr_s     = access_s & pwrite_i;
   assign rd_s     = access_s & ~pwrite_i;
   assign mapped_s = (paddr_i == `CCS_ADDR) || (paddr_i == `RHB_ADDR)
                  || (paddr_i == `RLB_ADDR) || (paddr_i == `IRQ_STAT_ADDR)
                  || (paddr_i == `IRQ_MASK_ADDR) || (paddr_i == `STAB_ADDR);
   assign wr_ccs_s = wr_s & (paddr_i == `CCS_ADDR) & pstrb_i[0];
   assign rd_rhb_s = rd_s & (paddr_i == `RHB_ADDR);

   // one wait state: pready rises in the second access cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pready_o <= 1'b0;
      end else begin
         pready_o <= psel_i & penable_i & ~pready_o;
      end
   end

   // ----------------------------------------
   // control register
   // ----------------------------------------
   conv_ctl_pkg::ctl_s ctl_q;
   logic               chan_change_s;

   assign chan_change_s = wr_ccs_s & (pwdata_i[3:0] != ctl_q.channel_select);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_q <= '0;
      end else if (wr_ccs_s) begin
         ctl_q.speed          <= pwdata_i[`CCS_SPEED_BIT];
         ctl_q.converter_on   <= pwdata_i[`CCS_ON_BIT];
         ctl_q.channel_select <= pwdata_i[3:0];
      end
   end

   // ----------------------------------------
   // converter clock divider
   // ----------------------------------------
   logic [1:0] div_q;
   logic       tick_s;

   // divider is restarted with each conversion so length is exact
   assign tick_s = ctl_q.speed ? div_q[0] : (div_q == 2'h3);

   // ----------------------------------------
   // conversion sequencer
   // ----------------------------------------
   conv_ctl_pkg::conv_state_e state_q;
   logic [3:0]                bit_cnt_q;
   logic [15:0]               stab_cnt_q;
   logic                      halted_q;
   logic                      finish_s;
   logic                      restart_s;

   assign finish_s  = (state_q == conv_ctl_pkg::ST_CONV) & tick_s
                    & (bit_cnt_q == `CONV_CYCLES - 4'h1);
   // a channel change restarts, abandoning the partial result
   assign restart_s = chan_change_s | finish_s;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         halted_q <= 1'b0;
      end else begin
         halted_q <= halt_s;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q    <= conv_ctl_pkg::ST_OFF;
         bit_cnt_q  <= 4'h0;
         div_q      <= 2'h0;
         stab_cnt_q <= 16'h0;
      end else if (!ctl_q.converter_on || halt_s) begin
         state_q    <= conv_ctl_pkg::ST_OFF;
         bit_cnt_q  <= 4'h0;
         div_q      <= 2'h0;
         stab_cnt_q <= 16'h0;
      end else begin
         unique case (state_q)
            conv_ctl_pkg::ST_OFF: begin
               // only a wake from halt pays the settling wait
               state_q <= halted_q ? conv_ctl_pkg::ST_STAB : conv_ctl_pkg::ST_CONV;
               stab_cnt_q <= 16'h0;
            end
            conv_ctl_pkg::ST_STAB: begin
               stab_cnt_q <= stab_cnt_q + 16'h1;
               if (stab_cnt_q == 16'(`STAB_CYCLES - 1)) begin
                  state_q <= conv_ctl_pkg::ST_CONV;
               end
            end
            conv_ctl_pkg::ST_CONV: begin
               if (restart_s) begin
                  bit_cnt_q <= 4'h0;
                  div_q     <= 2'h0;
               end else begin
                  div_q <= div_q + 2'h1;
                  if (tick_s) begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end
               end
            end
            default: state_q <= conv_ctl_pkg::ST_OFF;
         endcase
      end
   end

   // halt level before stab wait is remembered past the off state
   logic wake_pend_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_pend_q <= 1'b0;
      end else if (halt_s) begin
         wake_pend_q <= 1'b1;
      end else if (state_q == conv_ctl_pkg::ST_CONV) begin
         wake_pend_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // result and done flag
   // ----------------------------------------
   conv_ctl_pkg::result_s res_q;
   logic                  stab_evt_s;

   assign stab_evt_s = (state_q == conv_ctl_pkg::ST_STAB)
                     & (stab_cnt_q == 16'(`STAB_CYCLES - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res_q.data <= `RES_RESET;
      end else if (finish_s & ~chan_change_s) begin
         res_q.data <= core_result_i;
      end
   end

   // write-to-clear wins over the finish only on a channel change, which aborts
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res_q.done <= 1'b0;
      end else if (finish_s & ~chan_change_s) begin
         res_q.done <= 1'b1;
      end else if (wr_ccs_s | rd_rhb_s) begin
         res_q.done <= 1'b0;
      end
   end

   // ----------------------------------------
   // interrupt status and mask
   // ----------------------------------------
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   logic [1:0] irq_evt_s;
   logic       wr_stat_s;
   logic       wr_mask_s;

   assign irq_evt_s = {stab_evt_s, finish_s & ~chan_change_s};
   assign wr_stat_s = wr_s & (paddr_i == `IRQ_STAT_ADDR) & pstrb_i[0];
   assign wr_mask_s = wr_s & (paddr_i == `IRQ_MASK_ADDR) & pstrb_i[0];

   // set wins over a write-one-to-clear landing in the same cycle
   for (genvar i = 0; i < 2; i = i + 1) begin : g_irq
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            irq_stat_q[i] <= 1'b0;
         end else if (irq_evt_s[i]) begin
            irq_stat_q[i] <= 1'b1;
         end else if (wr_stat_s && pwdata_i[i]) begin
            irq_stat_q[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_q <= 2'h0;
      end else if (wr_mask_s) begin
         irq_mask_q <= pwdata_i[1:0];
      end
   end

   // an arriving event counts at once, but only through its mask bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |((irq_evt_s | irq_stat_q) & irq_mask_q);
      end
   end

   // ----------------------------------------
   // read mux and outputs
   // ----------------------------------------
   logic [7:0] ccs_rd_s;

   assign ccs_rd_s = {res_q.done, ctl_q.speed, ctl_q.converter_on, 1'b0,
                      ctl_q.channel_select};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prdata_o  <= 32'h0;
         pslverr_o <= 1'b0;
      end else begin
         pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped_s;
         prdata_o  <= 32'h0;
         if (psel_i & penable_i & ~pready_o & ~pwrite_i) begin
            unique case (paddr_i)
               `CCS_ADDR:      prdata_o <= {24'h0, ccs_rd_s};
               `RHB_ADDR:      prdata_o <= {24'h0, res_q.data[9:2]};
               `RLB_ADDR:      prdata_o <= {30'h0, res_q.data[1:0]};
               `IRQ_STAT_ADDR: prdata_o <= {30'h0, irq_stat_q};
               `IRQ_MASK_ADDR: prdata_o <= {30'h0, irq_mask_q};
               `STAB_ADDR:     prdata_o <= {30'h0, wake_pend_q,
                                            state_q == conv_ctl_pkg::ST_STAB};
               default:        prdata_o <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         converter_on_o   <= 1'b0;
         channel_select_o <= 4'h0;
         sample_start_o   <= 1'b0;
      end else begin
         converter_on_o   <= ctl_q.converter_on & ~halt_s;
         channel_select_o <= ctl_q.channel_select;
         sample_start_o   <= (state_q == conv_ctl_pkg::ST_CONV) & restart_s;
      end
   end

endmodule
`default_nettype wire

/* include/conv_ctl_defs.svh */
`ifndef CONV_CTL_DEFS_SVH
`define CONV_CTL_DEFS_SVH

// ----------------------------------------
// register map (printed offsets are not multiples of four: index * 4)
// ----------------------------------------
`define CCS_IDX          8'h70
`define RHB_IDX          8'h71
`define RLB_IDX          8'h72
`define IRQ_STAT_IDX     8'h73
`define IRQ_MASK_IDX     8'h74
`define STAB_IDX         8'h75
`define CCS_ADDR         12'h1c0
`define RHB_ADDR         12'h1c4
`define RLB_ADDR         12'h1c8
`define IRQ_STAT_ADDR    12'h1cc
`define IRQ_MASK_ADDR    12'h1d0
`define STAB_ADDR        12'h1d4

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CCS_DONE_BIT     7
`define CCS_SPEED_BIT    6
`define CCS_ON_BIT       5
`define CCS_RSVD_BIT     4
`define CCS_RESET        8'h00
`define RES_RESET        10'h000
`define IRQ_DONE_BIT     0
`define IRQ_STAB_BIT     1

// ----------------------------------------
// timing
// ----------------------------------------
`define CONV_CYCLES      4'hb
`define STAB_TIME_NS     1000
`define CLK_PERIOD_NS    10
`define STAB_CYCLES      ((`STAB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* include/conv_ctl_pkg.sv */
package conv_ctl_pkg;

   typedef enum logic [1:0] {
      ST_OFF,
      ST_STAB,
      ST_CONV
   } conv_state_e;

   typedef struct packed {
      logic       speed;
      logic       converter_on;
      logic [3:0] channel_select;
   } ctl_s;

   typedef struct packed {
      logic       done;
      logic [9:0] data;
   } result_s;

endpackage

/* tb/conv_ctl_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "conv_ctl_defs.svh"
module conv_ctl_monitor (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0]  pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        halt_mode_i,
   input wire logic        converter_on_o,
   input wire logic [3:0]  channel_select_o,
   input wire logic        sample_start_o,
   input wire logic        irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic       acc;
   logic       cwr;
   logic [7:0] gap_q;
   assign acc = psel_i && penable_i && pready_o;
   assign cwr = acc && pwrite_i && paddr_i == `CCS_ADDR && pstrb_i[0];
   // ----------------------------------------
   // restart watchdog
   // ----------------------------------------
   // bound covers sync, stabilization wait and one slow conversion
   always_ff @(posedge clk_i) begin
      if (rst_i || !converter_on_o || sample_start_o) gap_q <= 8'h00;
      else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
   end
   a_wait_state: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
      else $error("ready not after one wait state");
   a_err_unmapped: assert property (acc && !(paddr_i inside {`CCS_ADDR, `RHB_ADDR, `RLB_ADDR,
      `IRQ_STAT_ADDR, `IRQ_MASK_ADDR, `STAB_ADDR}) |-> pslverr_o && prdata_o == 32'h0)
      else $error("unmapped access not refused");
   a_rsvd_zero: assert property (
      acc && !pwrite_i && paddr_i == `CCS_ADDR |-> prdata_o[31:8] == 24'h0 && !prdata_o[4])
      else $error("reserved control bits not zero");
   a_low_zero: assert property (
      acc && !pwrite_i && paddr_i == `RLB_ADDR |-> prdata_o[31:2] == 30'h0)
      else $error("result low upper bits not zero");
   a_chan_restart: assert property (cwr && pwdata_i[5] && converter_on_o &&
      pwdata_i[3:0] != channel_select_o |-> ##[1:4] sample_start_o)
      else $error("channel change did not restart");
   a_off_stops: assert property (cwr && !pwdata_i[5] |-> ##[1:3] !converter_on_o)
      else $error("converter still on after clear");
   a_halt_off: assert property (halt_mode_i [*5] |-> !converter_on_o)
      else $error("converter on while halted");
   a_reset_zero: assert property ($fell(rst_i) |->
      !converter_on_o && channel_select_o == 4'h0 && !irq_o)
      else $error("outputs not zero after reset");
   a_restart_gap: assert property (gap_q < 8'hb4)
      else $error("enabled converter stopped restarting");
endmodule
bind conv_ctl conv_ctl_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .halt_mode_i(halt_mode_i), .converter_on_o(converter_on_o),
   .channel_select_o(channel_select_o), .sample_start_o(sample_start_o), .irq_o(irq_o));
`default_nettype wire

/* tb/adc_control_status_logic_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "conv_ctl_defs.svh"
module adc_control_status_logic_test;
   logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, wait_mode_i, halt_mode_i;
   logic        pready_o, pslverr_o, converter_on_o, sample_start_o, irq_o, e;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, q;
   logic [3:0]  pstrb_i, channel_select_o;
   logic [9:0]  core_result_i;
   int          fails = 0;
   int          checks_done = 0;
   int          n;
   conv_ctl uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .wait_mode_i(wait_mode_i), .halt_mode_i(halt_mode_i), .core_result_i(core_result_i),
      .converter_on_o(converter_on_o), .channel_select_o(channel_select_o),
      .sample_start_o(sample_start_o), .irq_o(irq_o));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // apb tasks
   // ----------------------------------------
   task chk(input logic [31:0] s, input logic [31:0] x);
      checks_done++;
      if (s !== x) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   task acc(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel_i <= 1'b1;
      paddr_i <= a;
      pwrite_i <= w;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      // only the watchdog ends a wait that never gets an answer
      while (pready_o !== 1'b1) begin
         @(posedge clk_i);
      end
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] x);
      acc(a, 1'b0, 32'h0);
      chk(q, x);
   endtask
   // counts edges up to the next restart pulse, 300 if none
   task gap(output int m);
      m = 0;
      while (sample_start_o !== 1'b1 && m < 300) begin
         @(posedge clk_i);
         m++;
      end
   endtask
   task per(input int x);
      gap(n);
      @(posedge clk_i);
      gap(n);
      @(posedge clk_i);
      gap(n);
      chk(n + 1, x);
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      test_done;
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {psel_i, penable_i, pwrite_i, wait_mode_i, halt_mode_i} = 5'h00;
      paddr_i = 12'h000;
      pwdata_i = 32'h0;
      pstrb_i = 4'h1;
      core_result_i = 10'h2b5;
      rst_i = 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`CCS_ADDR, 32'h0);
      rd(`RHB_ADDR, 32'h0);
      rd(`RLB_ADDR, 32'h0);
      rd(12'h1d8, 32'h0);
      chk(32'(e), 32'h1);
      $display("reset test done");
      // done written as one must read zero; reserved kept clear by software
      for (int c = 0; c < 16; c++) begin
         acc(`CCS_ADDR, 1'b1, {24'h0, 1'b1, c[0], 2'b00, c[3:0]});
         rd(`CCS_ADDR, {24'h0, 1'b0, c[0], 2'b00, c[3:0]});
         chk({28'h0, channel_select_o}, c);
      end
      $display("field test done");
      wait_mode_i <= 1'b1;
      acc(`CCS_ADDR, 1'b1, 32'h23);
      per(44);
      chk(32'(irq_o), 32'h0);
      rd(`IRQ_STAT_ADDR, 32'h1);
      acc(`IRQ_MASK_ADDR, 1'b1, 32'h1);
      repeat (2) @(posedge clk_i);
      chk(32'(irq_o), 32'h1);
      rd(`CCS_ADDR, 32'ha3);
      rd(`RLB_ADDR, 32'h1);
      rd(`RHB_ADDR, 32'had);
      rd(`CCS_ADDR, 32'h23);
      acc(`IRQ_STAT_ADDR, 1'b1, 32'h1);
      repeat (2) @(posedge clk_i);
      chk(32'(irq_o), 32'h0);
      $display("conversion test done");
      acc(`CCS_ADDR, 1'b1, 32'h63);
      core_result_i <= 10'h0c3;
      per(22);
      rd(`RLB_ADDR, 32'h3);
      rd(`RHB_ADDR, 32'h30);
      acc(`CCS_ADDR, 1'b1, 32'h23);
      per(44);
      repeat (10) @(posedge clk_i);
      acc(`CCS_ADDR, 1'b1, 32'h25);
      rd(`CCS_ADDR, 32'h25);
      gap(n);
      chk(32'(n > 32), 32'h1);
      chk({28'h0, channel_select_o}, 32'h5);
      $display("channel test done");
      acc(`CCS_ADDR, 1'b1, 32'h05);
      gap(n);
      chk(n, 300);
      chk(32'(converter_on_o), 32'h0);
      acc(`CCS_ADDR, 1'b1, 32'h25);
      halt_mode_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk(32'(converter_on_o), 32'h0);
      halt_mode_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      rd(`STAB_ADDR, 32'h3);
      gap(n);
      chk(32'(n >= 100 && n < 300), 32'h1);
      rd(`IRQ_STAT_ADDR, 32'h3);
      $display("power test done");
      test_done;
   end
endmodule
`default_nettype wire
